// ### mcc_regs.svh
`ifndef MCC_REGS_SVH
`define MCC_REGS_SVH
`define MCC_OFS_SRCSEL 3'h0
`define MCC_OFS_PRESC 3'h1
`define MCC_OFS_MONCTL 3'h2
`define MCC_OFS_INTCTL 3'h3
`define MCC_OFS_FLAGS 3'h4
`define MCC_OFS_STATUS 3'h5
`define MCC_RST_SRCSEL 8'h00
`define MCC_RST_PRESC 8'h00
`define MCC_RST_MONCTL 8'h00
`define MCC_RST_INTCTL 8'h00
`define MCC_BIT_MAIN_CLOCK_OUTPUT_ENABLE 7
`define MCC_BIT_PEN 0
`define MCC_BIT_MONEN 0
`define MCC_BIT_TEST 1
`define MCC_BIT_IRQKIND 7
`define MCC_BIT_IRQEN 0
`define MCC_BIT_FAIL 0
`define MCC_MASK_SRCSEL 8'h8F
`define MCC_MASK_PRESC 8'h1F
`define MCC_MASK_MONCTL 8'h0F
`define MCC_MASK_INTCTL 8'h81
`define MCC_GUARD_KEY 8'hD8
`define MCC_GUARD_WINDOW 3'h4
`define MCC_RETRIG_TICKS 4'hA
`endif

// ### mcc_pkg.sv
package mcc_pkg;
	typedef enum logic [1:0] {
		MCC_MON_MAIN = 2'h0,
		MCC_MON_EXT_HF = 2'h1,
		MCC_MON_EXT_32K = 2'h2
	} mcc_mon_src_t;
	typedef enum logic [2:0] {
		MCC_SW_IDLE = 3'b001,
		MCC_SW_WAIT = 3'b010,
		MCC_SW_DONE = 3'b100
	} mcc_sw_state_t;
endpackage : mcc_pkg

// ### mcc_prescaler.sv
`timescale 1ns/10ps
module mcc_prescaler (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic enable,
	input wire logic [3:0] ratio,
	output logic tick
);
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic [5:0] top;
	logic next_tick;

	always_comb begin
		unique case (ratio)
			4'h0: top = 6'h01;
			4'h1: top = 6'h03;
			4'h2: top = 6'h07;
			4'h3: top = 6'h0F;
			4'h4: top = 6'h1F;
			4'h5: top = 6'h3F;
			4'h8: top = 6'h05;
			4'h9: top = 6'h09;
			4'hA: top = 6'h0B;
			4'hB: top = 6'h17;
			4'hC: top = 6'h2F;
			default: top = 6'h01;
		endcase
	end

	always_comb begin
		next_cnt = cnt;
		next_tick = 1'b1;
		if (enable) begin
			next_tick = (cnt == top);
			next_cnt = (cnt >= top) ? 6'h00 : cnt + 6'h01;
		end else begin
			next_cnt = 6'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt <= 6'h00;
			tick <= 1'b0;
		end else if (ce) begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule : mcc_prescaler

// ### mcc_main_clock_ctrl.sv
`timescale 1ns/10ps
`include "mcc_regs.svh"
module mcc_main_clock_ctrl (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic guard_key_wr,
	input wire logic [7:0] guard_key,
	input wire logic instr_step,
	input wire logic internal_hf_stable,
	input wire logic internal_32k_stable,
	input wire logic external_32k_status,
	input wire logic external_hf_status,
	input wire logic pll_running_status,
	input wire logic internal_32k_oscillator_tick,
	input wire logic monitored_main_fail,
	input wire logic monitored_ext_hf_fail,
	input wire logic monitored_ext_32k_fail,
	output logic main_clock_out_gate,
	output logic [3:0] main_source_select,
	output logic peripheral_clock_enable,
	output logic failure_irq,
	output logic failure_nmi,
	output logic fallback_to_startup
);
	import mcc_pkg::*;

	logic [7:0] srcsel;
	logic [7:0] presc;
	logic [7:0] monctl;
	logic [7:0] intctl;
	logic fail_flag;
	logic locked;
	logic [2:0] guard_cnt;
	logic [3:0] retrig_cnt;
	logic [3:0] active_src;
	mcc_sw_state_t sw_state;
	logic [4:0] st_s1;
	logic [4:0] st_s2;
	logic [2:0] fl_s1;
	logic [2:0] fl_s2;
	logic tick_s1;
	logic tick_s2;
	logic tick_s3;

	logic [7:0] next_srcsel;
	logic [7:0] next_presc;
	logic [7:0] next_monctl;
	logic [7:0] next_intctl;
	logic next_fail_flag;
	logic next_locked;
	logic [2:0] next_guard_cnt;
	logic [3:0] next_retrig_cnt;
	logic [3:0] next_active_src;
	mcc_sw_state_t next_sw_state;
	logic [7:0] next_rdata;
	logic next_gate;
	logic next_irq;
	logic next_nmi;
	logic next_fallback;

	logic guard_open;
	logic prot_wr;
	logic mon_en;
	logic raw_fail;
	logic fail_event;
	logic tick_rise;
	logic main_fail_cond;
	logic div_tick;
	logic src_stable;
	logic [5:0] status_val;

	mcc_prescaler u_presc (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.enable(presc[`MCC_BIT_PEN]),
		.ratio(presc[4:1]),
		.tick(div_tick)
	);

	// Pin-level status and fail inputs pass two flip-flops; the 32k oscillator tick passes three
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_s1 <= 5'h00;
			st_s2 <= 5'h00;
			fl_s1 <= 3'h0;
			fl_s2 <= 3'h0;
			tick_s1 <= 1'b0;
			tick_s2 <= 1'b0;
			tick_s3 <= 1'b0;
		end else if (ce) begin
			st_s1 <= {pll_running_status, external_hf_status, external_32k_status,
				internal_32k_stable, internal_hf_stable};
			st_s2 <= st_s1;
			fl_s1 <= {monitored_ext_32k_fail, monitored_ext_hf_fail, monitored_main_fail};
			fl_s2 <= fl_s1;
			tick_s1 <= internal_32k_oscillator_tick;
			tick_s2 <= tick_s1;
			tick_s3 <= tick_s2;
		end
	end

	assign tick_rise = tick_s2 & ~tick_s3;
	assign guard_open = (guard_cnt != 3'h0);
	assign prot_wr = reg_wr & guard_open;
	assign mon_en = monctl[`MCC_BIT_MONEN];

	always_comb begin
		unique case (monctl[3:2])
			MCC_MON_MAIN: raw_fail = fl_s2[0];
			MCC_MON_EXT_HF: raw_fail = fl_s2[1];
			MCC_MON_EXT_32K: raw_fail = fl_s2[2];
			default: raw_fail = 1'b0;
		endcase
	end

	// Test force ORs into selected failure
	assign fail_event = mon_en & (raw_fail | monctl[`MCC_BIT_TEST]);
	assign main_fail_cond = fail_event & (monctl[3:2] == MCC_MON_MAIN);

	always_comb begin
		unique case (srcsel[3:0])
			4'h0: src_stable = st_s2[0];
			4'h1: src_stable = st_s2[1];
			4'h2: src_stable = st_s2[2];
			4'h3: src_stable = st_s2[3];
			default: src_stable = 1'b0;
		endcase
	end

	assign status_val = {st_s2, sw_state == MCC_SW_WAIT};

	always_comb begin
		next_guard_cnt = guard_cnt;
		if (guard_key_wr && guard_key == `MCC_GUARD_KEY) begin
			next_guard_cnt = `MCC_GUARD_WINDOW;
		end else if (reg_wr && guard_open) begin
			next_guard_cnt = 3'h0;
		end else if (instr_step && guard_open) begin
			next_guard_cnt = guard_cnt - 3'h1;
		end
	end

	always_comb begin
		next_srcsel = srcsel;
		next_presc = presc;
		next_monctl = monctl;
		next_intctl = intctl;
		next_locked = locked | (monctl[`MCC_BIT_MONEN] & intctl[`MCC_BIT_IRQEN]
			& intctl[`MCC_BIT_IRQKIND]);
		if (prot_wr) begin
			unique case (reg_addr)
				`MCC_OFS_SRCSEL: next_srcsel = reg_wdata & `MCC_MASK_SRCSEL;
				`MCC_OFS_PRESC: next_presc = reg_wdata & `MCC_MASK_PRESC;
				`MCC_OFS_MONCTL: begin
					if (locked) begin
						next_monctl[`MCC_BIT_TEST] = reg_wdata[`MCC_BIT_TEST];
					end else begin
						next_monctl = reg_wdata & `MCC_MASK_MONCTL;
					end
				end
				`MCC_OFS_INTCTL: begin
					if (!locked) begin
						next_intctl = reg_wdata & `MCC_MASK_INTCTL;
					end
				end
				default: ;
			endcase
		end
		if (main_fail_cond) begin
			next_srcsel[`MCC_BIT_MAIN_CLOCK_OUTPUT_ENABLE] = 1'b0;
			next_srcsel[3:0] = 4'h0;
		end
	end

	always_comb begin
		next_fail_flag = fail_flag;
		next_retrig_cnt = retrig_cnt;
		if (reg_wr && reg_addr == `MCC_OFS_FLAGS && reg_wdata[`MCC_BIT_FAIL]) begin
			next_fail_flag = 1'b0;
		end
		if (!fail_event) begin
			next_retrig_cnt = 4'h0;
		end else if (retrig_cnt == 4'h0) begin
			next_fail_flag = 1'b1;
			next_retrig_cnt = `MCC_RETRIG_TICKS;
		end else if (tick_rise) begin
			next_retrig_cnt = retrig_cnt - 4'h1;
		end
	end

	always_comb begin
		next_active_src = active_src;
		next_sw_state = sw_state;
		unique case (sw_state)
			MCC_SW_IDLE: begin
				if (srcsel[3:0] != active_src) begin
					next_sw_state = MCC_SW_WAIT;
				end
			end
			MCC_SW_WAIT: begin
				if (src_stable || srcsel[3:0] == active_src) begin
					next_sw_state = MCC_SW_DONE;
				end
			end
			MCC_SW_DONE: begin
				next_active_src = srcsel[3:0];
				next_sw_state = MCC_SW_IDLE;
			end
			default: next_sw_state = MCC_SW_IDLE;
		endcase
		// Startup source taken at once, no stability wait
		if (main_fail_cond) begin
			next_active_src = 4'h0;
			next_sw_state = MCC_SW_IDLE;
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`MCC_OFS_SRCSEL: next_rdata = srcsel;
				`MCC_OFS_PRESC: next_rdata = presc;
				`MCC_OFS_MONCTL: next_rdata = monctl;
				`MCC_OFS_INTCTL: next_rdata = intctl;
				`MCC_OFS_FLAGS: next_rdata = {7'h00, fail_flag};
				`MCC_OFS_STATUS: next_rdata = {2'h0, status_val};
				default: next_rdata = 8'h00;
			endcase
		end
		next_gate = srcsel[`MCC_BIT_MAIN_CLOCK_OUTPUT_ENABLE];
		next_irq = intctl[`MCC_BIT_IRQEN] & fail_flag & ~intctl[`MCC_BIT_IRQKIND];
		next_nmi = intctl[`MCC_BIT_IRQEN] & fail_flag & intctl[`MCC_BIT_IRQKIND];
		next_fallback = main_fail_cond;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			srcsel <= `MCC_RST_SRCSEL;
			presc <= `MCC_RST_PRESC;
			monctl <= `MCC_RST_MONCTL;
			intctl <= `MCC_RST_INTCTL;
			fail_flag <= 1'b0;
			locked <= 1'b0;
			guard_cnt <= 3'h0;
			retrig_cnt <= 4'h0;
			active_src <= 4'h0;
			sw_state <= MCC_SW_IDLE;
			reg_rdata <= 8'h00;
			main_clock_out_gate <= 1'b0;
			main_source_select <= 4'h0;
			peripheral_clock_enable <= 1'b0;
			failure_irq <= 1'b0;
			failure_nmi <= 1'b0;
			fallback_to_startup <= 1'b0;
		end else if (ce) begin
			srcsel <= next_srcsel;
			presc <= next_presc;
			monctl <= next_monctl;
			intctl <= next_intctl;
			fail_flag <= next_fail_flag;
			locked <= next_locked;
			guard_cnt <= next_guard_cnt;
			retrig_cnt <= next_retrig_cnt;
			active_src <= next_active_src;
			sw_state <= next_sw_state;
			reg_rdata <= next_rdata;
			main_clock_out_gate <= next_gate;
			main_source_select <= next_active_src;
			peripheral_clock_enable <= div_tick;
			failure_irq <= next_irq;
			failure_nmi <= next_nmi;
			fallback_to_startup <= next_fallback;
		end
	end
endmodule : mcc_main_clock_ctrl

// ### mcc_checker.sv
`timescale 1ns/10ps
module mcc_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic main_clock_out_gate,
	input wire logic [3:0] main_source_select,
	input wire logic failure_irq,
	input wire logic failure_nmi,
	input wire logic fallback_to_startup
);
	logic wr0;
	assign wr0 = reg_wr && reg_addr == 3'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	irq_kind_excl_a: assert property (!(failure_irq && failure_nmi))
		else $error("maskable and nonmaskable requests together");
	reset_quiet_a: assert property ($rose(rstn) |-> !failure_irq && !failure_nmi
		&& !main_clock_out_gate) else $error("outputs active after reset");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without a read");
	irq_hold_a: assert property (failure_irq && !reg_wr && !$past(reg_wr) |=> failure_irq)
		else $error("request dropped without a write");
	nmi_hold_a: assert property (failure_nmi && !reg_wr && !$past(reg_wr) |=> failure_nmi)
		else $error("nonmaskable request dropped without a write");
	gate_rise_a: assert property ($rose(main_clock_out_gate) |-> $past(wr0) || $past(wr0, 2))
		else $error("clock output enabled without a write");
	fallback_src_a: assert property (fallback_to_startup |-> main_source_select == 4'h0)
		else $error("fallback without startup source");
	status_resv_a: assert property (reg_rd && reg_addr == 3'h5 |=> reg_rdata[7:6] == 2'b00)
		else $error("status reserved bits set");
	flags_resv_a: assert property (reg_rd && reg_addr == 3'h4 |=> reg_rdata[7:1] == 7'h00)
		else $error("flag reserved bits set");
endmodule : mcc_checker

bind mcc_main_clock_ctrl mcc_checker u_chk (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.main_clock_out_gate(main_clock_out_gate), .main_source_select(main_source_select),
	.failure_irq(failure_irq), .failure_nmi(failure_nmi),
	.fallback_to_startup(fallback_to_startup));

// ### testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
	$display("unexpected %0t: got %h want %h", $time, a, b); end end
module testbench;
	logic clk = 0, rstn = 0, rd = 0, wr = 0, kw = 0, st = 0, tk = 0, mf = 0;
	logic [2:0] ad = 0;
	logic [7:0] wd = 0, rdat;
	logic ce = 1, hf_f = 0, x32_f = 0;
	logic [7:0] key = 8'hD8;
	logic [4:0] sts = 0;
	logic gate, irq, nmi, fb, pce;
	logic [3:0] src;
	integer fail_count = 0, check_count = 0, seed = 32'he5d7799e, i, p;
	mcc_main_clock_ctrl u_dut (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(ad), .reg_wr(wr),
		.reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat), .guard_key_wr(kw), .guard_key(key),
		.instr_step(st), .internal_hf_stable(sts[0]), .internal_32k_stable(sts[1]),
		.external_32k_status(sts[2]), .external_hf_status(sts[3]), .pll_running_status(sts[4]),
		.internal_32k_oscillator_tick(tk), .monitored_main_fail(mf), .monitored_ext_hf_fail(hf_f),
		.monitored_ext_32k_fail(x32_f), .main_clock_out_gate(gate), .main_source_select(src),
		.peripheral_clock_enable(pce), .failure_irq(irq), .failure_nmi(nmi),
		.fallback_to_startup(fb));
	initial forever #12.5 clk = ~clk;
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	// Optional key cycle, then one write strobe
	task w(input logic [2:0] a, input logic [7:0] d, input int g);
		kw = (g != 0);
		cyc(1);
		kw = 0;
		ad = a;
		wd = d;
		wr = 1;
		cyc(1);
		wr = 0;
		cyc(1);
	endtask : w
	task r(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		ad = a;
		rd = 1;
		cyc(1);
		rd = 0;
		`CHK(rdat & m, e)
	endtask : r
	task tks(input int k);
		repeat (k) begin
			tk = 1;
			cyc(3);
			tk = 0;
			cyc(3);
		end
	endtask : tks
	// Cycles between two enable pulses
	task per;
		for (p = 0; p < 200 && !pce; p++) cyc(1);
		cyc(1);
		for (p = 1; p < 200 && !pce; p++) cyc(1);
	endtask : per
	function int dv(input logic [3:0] c);
		case (c)
			0: dv = 2;
			1: dv = 4;
			2: dv = 8;
			3: dv = 16;
			4: dv = 32;
			5: dv = 64;
			8: dv = 6;
			9: dv = 10;
			10: dv = 12;
			11: dv = 24;
			12: dv = 48;
			default: dv = 2;
		endcase
	endfunction : dv
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim
	initial begin
		#1000000;
		fail_count++;
		end_sim;
	end
	initial begin
		cyc(10);
		rstn = 1;
		cyc(1);
		for (i = 0; i < 5; i++) r(i[2:0], 8'hFF, 8'h00);
		for (i = 0; i < 4; i++) begin
			sts = 5'($random(seed));
			cyc(4);
			r(3'h5, 8'h3E, {2'b00, sts, 1'b0});
		end
		w(3'h5, 8'hFF, 1);
		r(3'h5, 8'h3E, {2'b00, sts, 1'b0});
		sts = 5'h1F;
		$display("status done");
		w(3'h0, 8'h83, 0);
		r(3'h0, 8'hFF, 8'h00);
		key = 8'h5A;
		w(3'h0, 8'h83, 1);
		r(3'h0, 8'hFF, 8'h00);
		key = 8'hD8;
		kw = 1;
		cyc(1);
		kw = 0;
		st = 1;
		cyc(5);
		st = 0;
		w(3'h0, 8'h83, 0);
		r(3'h0, 8'hFF, 8'h00);
		sts = 5'h00;
		cyc(4);
		w(3'h0, 8'h01, 1);
		r(3'h5, 8'h01, 8'h01);
		sts = 5'h1F;
		cyc(6);
		r(3'h5, 8'hFF, 8'h3E);
		`CHK(src, 4'h1)
		w(3'h0, 8'hF3, 1);
		r(3'h0, 8'hFF, 8'h83);
		`CHK(gate, 1'b1)
		w(3'h2, 8'h01, 1);
		mf = 1;
		cyc(6);
		`CHK({gate, fb, src}, 6'h10)
		r(3'h4, 8'hFF, 8'h01);
		mf = 0;
		w(3'h2, 8'h00, 1);
		w(3'h4, 8'h01, 0);
		r(3'h4, 8'hFF, 8'h00);
		$display("guard done");
		for (i = 0; i < 16; i++) begin
			w(3'h1, {3'b000, i[3:0], 1'b1}, 1);
			per;
			per;
			`CHK(p, dv(i[3:0]))
		end
		r(3'h1, 8'hFF, 8'h1F);
		w(3'h1, 8'h00, 1);
		cyc(3);
		`CHK(pce, 1'b1)
		ce = 0;
		w(3'h1, 8'h03, 1);
		`CHK(pce, 1'b1)
		ce = 1;
		r(3'h1, 8'hFF, 8'h00);
		$display("prescale done");
		w(3'h3, 8'h01, 1);
		w(3'h2, 8'h06, 1);
		cyc(6);
		r(3'h4, 8'hFF, 8'h00);
		w(3'h2, 8'h07, 1);
		cyc(6);
		r(3'h4, 8'hFF, 8'h01);
		`CHK({irq, nmi}, 2'b10)
		w(3'h4, 8'h00, 0);
		r(3'h4, 8'hFF, 8'h01);
		w(3'h4, 8'h01, 0);
		r(3'h4, 8'hFF, 8'h00);
		`CHK(irq, 1'b0)
		tks(11);
		r(3'h4, 8'hFF, 8'h01);
		w(3'h2, 8'h05, 1);
		w(3'h4, 8'h01, 0);
		tks(11);
		r(3'h4, 8'hFF, 8'h00);
		x32_f = 1;
		cyc(6);
		r(3'h4, 8'hFF, 8'h00);
		w(3'h2, 8'h09, 1);
		cyc(4);
		r(3'h4, 8'hFF, 8'h01);
		x32_f = 0;
		w(3'h2, 8'h05, 1);
		w(3'h4, 8'h01, 0);
		hf_f = 1;
		cyc(6);
		r(3'h4, 8'hFF, 8'h01);
		hf_f = 0;
		w(3'h4, 8'h01, 0);
		r(3'h4, 8'hFF, 8'h00);
		w(3'h3, 8'h81, 1);
		w(3'h2, 8'h07, 1);
		cyc(6);
		`CHK({irq, nmi}, 2'b01)
		w(3'h2, 8'h00, 1);
		w(3'h3, 8'h00, 1);
		r(3'h2, 8'hFF, 8'h05);
		r(3'h3, 8'hFF, 8'h81);
		rstn = 0;
		cyc(2);
		rstn = 1;
		cyc(1);
		r(3'h3, 8'hFF, 8'h00);
		$display("monitor done");
		end_sim;
	end
endmodule : testbench
